// ### logic/mem_window.sv
`timescale 1ns/1ps
`default_nettype none
module mem_window
   import pm_pin_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Address to classify and mode indication.
   input wire logic [31:0] addr,
   input wire logic smmActive,
   output logic hit_q
);

   // Registered hit for the protected window while in management mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= smmActive && addr >= MGMT_MEM_LO && addr <= MGMT_MEM_HI;
      end
   end

endmodule
`default_nettype wire

// ### logic/pm_pin_pkg.sv
package pm_pin_pkg;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] PIN_FUNC_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] CTRL_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] GPIO_OFS = 8'h10;

   // -------------------------------------------------------------
   // Mask register fields and reset
   // -------------------------------------------------------------
   localparam int EXT_PRI_BIT = 0;
   localparam int EXT_SEC_BIT = 1;
   localparam int WAKE0_BIT = 2;
   localparam int WAKE1_BIT = 3;
   localparam int SW_WAKE_BIT = 4;
   localparam int SW_PRI_BIT = 5;
   localparam int SW_MGMT_BIT = 6;
   localparam int DSLP_BIT = 7;
   localparam logic [7:0] MASK_RESET = 8'h10;

   // -------------------------------------------------------------
   // Control register fields
   // -------------------------------------------------------------
   localparam int CTRL_MGMT_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_SUSPEND_BIT = 2;
   localparam int CTRL_DEEP_BIT = 3;
   localparam int CTRL_INDICATOR_OUT_0_BIT = 4;
   localparam int CTRL_INDICATOR_OUT_1_BIT = 5;
   localparam int CTRL_CLKSTOP_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // -------------------------------------------------------------
   // Status register fields
   // -------------------------------------------------------------
   localparam int ST_PRI_BIT = 0;
   localparam int ST_SEC_BIT = 1;
   localparam int ST_WAKE_BIT = 2;
   localparam int ST_MGMT_BIT = 3;
   localparam int ST_SUSPENDED_BIT = 4;
   localparam int ST_DMAREQ_BIT = 5;
   localparam int ST_CLKOK_BIT = 6;
   localparam int ST_SMM_BIT = 7;

   // -------------------------------------------------------------
   // Pin function codes and management memory window
   // -------------------------------------------------------------
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_ALT1 = 2'h1;
   localparam logic [1:0] FUNC_ALT2 = 2'h2;
   localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
   localparam logic [31:0] MGMT_MEM_LO = 32'h000a0000;
   localparam logic [31:0] MGMT_MEM_HI = 32'h000bffff;

endpackage

// ### logic/power_management_pin_control.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module power_management_pin_control
   import pm_pin_pkg::*;
#(
   parameter logic [7:0] PIN_FUNC_INIT = PIN_FUNC_RESET
) (
   // Slow timebase clock and power-on reset.
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor side.
   output logic mgmtInterruptN,
   input wire logic mgmtModeActiveN,
   output logic stopClockRequestN,
   input wire logic [31:0] cpuAddr,
   output logic mgmtMemorySelect,
   // Activity and wake inputs.
   input wire logic externalActivityIn,
   input wire logic [1:0] resumeRequest,
   input wire logic powerSwitchInput,
   // Multiplexed pins 0 to 3.
   input wire logic [3:0] gpioIn,
   output logic [3:0] gpioOut,
   output logic [3:0] gpioOe,
   // Clock-run open-drain line.
   input wire logic clkRunIn,
   output logic clkRunOut,
   output logic clkRunOe,
   // Decoded activity events.
   output logic primaryActivity,
   output logic secondaryActivity,
   output logic distributedDmaBusRequest
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pinFunc;
      logic [7:0] mask;
      logic [7:0] ctrl;
      logic [3:0] gpioOut;
      logic [3:0] gpioOe;
      logic [3:0] status;
      logic suspended;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic mgmtIntN;
      logic stopN;
      logic clkRunDrv;
      logic pri;
      logic sec;
      logic dmaReq;
      logic wakeLast;
   } state_s;

   state_s st_q, st_d;
   logic [3:0] gpioSync;
   logic [1:0] resumeSync;
   logic extSync, swSync, smmSync, clkRunSync, memHit;
   logic access, anyWake;
   logic extPri, extSec, swPri, swMgmt, dslpWake;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gSyncGpio
         sync_bit #(.RESET_VAL(1'b0)) uSync (
            .clk(mclk),
            .rst_n(rst_n),
            .din(gpioIn[gi]),
            .dout(gpioSync[gi])
         );
      end
      for (gi = 0; gi < 2; gi++) begin : gSyncRes
         sync_bit #(.RESET_VAL(1'b0)) uSync (
            .clk(mclk),
            .rst_n(rst_n),
            .din(resumeRequest[gi]),
            .dout(resumeSync[gi])
         );
      end
   endgenerate

   sync_bit #(.RESET_VAL(1'b0)) uSyncExt (
      .clk(mclk),
      .rst_n(rst_n),
      .din(externalActivityIn),
      .dout(extSync)
   );

   sync_bit #(.RESET_VAL(1'b0)) uSyncSw (
      .clk(mclk),
      .rst_n(rst_n),
      .din(powerSwitchInput),
      .dout(swSync)
   );

   sync_bit #(.RESET_VAL(1'b1)) uSyncSmm (
      .clk(mclk),
      .rst_n(rst_n),
      .din(mgmtModeActiveN),
      .dout(smmSync)
   );

   sync_bit #(.RESET_VAL(1'b1)) uSyncClk (
      .clk(mclk),
      .rst_n(rst_n),
      .din(clkRunIn),
      .dout(clkRunSync)
   );

   // Management memory window decode while the processor is in SYSTEM_MANAGEMENT_MODE.
   mem_window uWindow (
      .clk(mclk),
      .rst_n(rst_n),
      .addr(cpuAddr),
      .smmActive(!smmSync),
      .hit_q(memHit)
   );

   // ---------------------------------------------------------------
   // Event sources, each gated by its own mask bit
   // ---------------------------------------------------------------
   always_comb begin
      extPri = extSync && st_q.mask[EXT_PRI_BIT];
      extSec = extSync && st_q.mask[EXT_SEC_BIT];
      swPri = swSync && st_q.mask[SW_PRI_BIT];
      swMgmt = swSync && st_q.mask[SW_MGMT_BIT];
      // Deep-sleep wake only through pin 2 in its wake function.
      dslpWake = st_q.ctrl[CTRL_DEEP_BIT] && st_q.mask[DSLP_BIT]
         && st_q.pinFunc[5:4] == FUNC_ALT2 && gpioSync[2];
      // External activity is deliberately absent from the wake set.
      anyWake = (resumeSync[0] && st_q.mask[WAKE0_BIT])
         || (resumeSync[1] && st_q.mask[WAKE1_BIT])
         || (swSync && st_q.mask[SW_WAKE_BIT])
         || dslpWake;
      // Resume inhibit on pin 3 blocks every wake.
      if (st_q.pinFunc[7:6] == FUNC_ALT1 && gpioSync[3]) begin
         anyWake = 1'b0;
      end
   end

   assign access = psel && penable;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.ready = 1'b0;
      st_d.slverr = 1'b0;
      st_d.wakeLast = anyWake;
      // Register writes and reads, one wait state per access.
      if (access && !st_q.ready) begin
         st_d.ready = 1'b1;
         st_d.rdata = 32'h00000000;
         if (pwrite) begin
            unique case (paddr)
               PIN_FUNC_OFS: st_d.pinFunc = pwdata[7:0];
               MASK_OFS: st_d.mask = pwdata[7:0];
               CTRL_OFS: st_d.ctrl = pwdata[7:0];
               STATUS_OFS: st_d.status = st_q.status & ~pwdata[3:0];
               GPIO_OFS: begin
                  st_d.gpioOut = pwdata[3:0];
                  st_d.gpioOe = pwdata[7:4];
               end
               default: st_d.slverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               PIN_FUNC_OFS: st_d.rdata = {24'h000000, st_q.pinFunc};
               MASK_OFS: st_d.rdata = {24'h000000, st_q.mask};
               CTRL_OFS: st_d.rdata = {24'h000000, st_q.ctrl};
               STATUS_OFS: st_d.rdata = {24'h000000, !smmSync, clkRunSync,
                  st_q.dmaReq, st_q.suspended, st_q.status};
               GPIO_OFS: st_d.rdata = {20'h00000, gpioSync,
                  st_q.gpioOe, st_q.gpioOut};
               default: st_d.slverr = 1'b1;
            endcase
         end
      end
      // Sticky event flags; a set wins over a clear in the same cycle.
      if (extPri || swPri || dslpWake) st_d.status[ST_PRI_BIT] = 1'b1;
      if (extSec) st_d.status[ST_SEC_BIT] = 1'b1;
      if (anyWake && st_q.suspended) st_d.status[ST_WAKE_BIT] = 1'b1;
      if (swMgmt) st_d.status[ST_MGMT_BIT] = 1'b1;
      // Suspend entry by software, exit by an unblocked wake edge.
      if (st_q.ctrl[CTRL_SUSPEND_BIT]) st_d.suspended = 1'b1;
      if (st_q.suspended && anyWake && !st_q.wakeLast) begin
         st_d.suspended = 1'b0;
         st_d.ctrl[CTRL_SUSPEND_BIT] = 1'b0;
         st_d.ctrl[CTRL_DEEP_BIT] = 1'b0;
      end
      // Management interrupt while requested or flagged by switch.
      st_d.mgmtIntN = !(st_q.ctrl[CTRL_MGMT_BIT]
         || st_d.status[ST_MGMT_BIT]);
      // Shared stop-clock or suspend request.
      st_d.stopN = !(st_q.ctrl[CTRL_STOP_BIT] || st_d.suspended);
      // Clock-run: drive low while clock is wanted, release to ask stop.
      st_d.clkRunDrv = !st_q.ctrl[CTRL_CLKSTOP_BIT];
      st_d.pri = extPri || swPri || dslpWake;
      st_d.sec = extSec;
      st_d.dmaReq = st_q.pinFunc[5:4] == FUNC_ALT1 && gpioSync[2];
   end

   // ---------------------------------------------------------------
   // State register on the slow timebase, loaded with its reset values by power-on reset
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.pinFunc <= PIN_FUNC_INIT;
         st_q.mask <= MASK_RESET;
         st_q.ctrl <= CTRL_RESET;
         st_q.mgmtIntN <= 1'b1;
         st_q.stopN <= 1'b1;
         st_q.clkRunDrv <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Pin 0 and 1 outputs: GPIO or indicator LED.
   logic [3:0] pinOut_q, pinOe_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pinOut_q <= 4'h0;
         pinOe_q <= 4'h0;
      end else begin
         pinOut_q[0] <= st_q.pinFunc[1:0] == FUNC_GPIO ? st_q.gpioOut[0]
            : st_q.ctrl[CTRL_INDICATOR_OUT_0_BIT];
         pinOe_q[0] <= st_q.pinFunc[1:0] == FUNC_GPIO ? st_q.gpioOe[0]
            : 1'b1;
         pinOut_q[1] <= st_q.pinFunc[3:2] == FUNC_GPIO ? st_q.gpioOut[1]
            : st_q.ctrl[CTRL_INDICATOR_OUT_1_BIT];
         pinOe_q[1] <= st_q.pinFunc[3:2] == FUNC_GPIO ? st_q.gpioOe[1]
            : 1'b1;
         // Pins 2 and 3 are inputs in their alternate functions.
         pinOut_q[2] <= st_q.gpioOut[2];
         pinOe_q[2] <= st_q.pinFunc[5:4] == FUNC_GPIO && st_q.gpioOe[2];
         pinOut_q[3] <= st_q.gpioOut[3];
         pinOe_q[3] <= st_q.pinFunc[7:6] == FUNC_GPIO && st_q.gpioOe[3];
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign mgmtInterruptN = st_q.mgmtIntN;
   assign stopClockRequestN = st_q.stopN;
   assign mgmtMemorySelect = memHit;
   assign gpioOut = pinOut_q;
   assign gpioOe = pinOe_q;
   assign clkRunOut = 1'b0;
   assign clkRunOe = st_q.clkRunDrv;
   assign primaryActivity = st_q.pri;
   assign secondaryActivity = st_q.sec;
   assign distributedDmaBusRequest = st_q.dmaReq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_inhibit_blocks_wake: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q.suspended && st_q.pinFunc[7:6] == FUNC_ALT1 && gpioSync[3]
       && !st_q.ctrl[CTRL_SUSPEND_BIT]) |=> st_q.suspended)
      else $error("Wake taken while resume inhibit active.");
   a_mgmt_int_follows: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q.ctrl[CTRL_MGMT_BIT] |=> !mgmtInterruptN)
      else $error("Management interrupt not asserted.");
   a_masked_ext_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      (!st_q.mask[EXT_SEC_BIT]) |=> !secondaryActivity)
      else $error("Masked source produced an event.");
   a_dma_request_level: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q.pinFunc[5:4] == FUNC_ALT1 && gpioSync[2])
      |=> distributedDmaBusRequest)
      else $error("DMA request not reported.");
   a_indicator_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q.pinFunc[1:0] != FUNC_GPIO) |=> gpioOe[0])
      else $error("Indicator pin 0 not driven.");
   a_window_outside: assert property (@(posedge mclk) disable iff (!rst_n)
      smmSync |=> !mgmtMemorySelect)
      else $error("Window selected outside management mode.");

endmodule
`default_nettype wire

// ### logic/sync_bit.sv
`timescale 1ns/1ps
`default_nettype none
module sync_bit
   import pm_pin_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous level in, synchronous level out.
   input wire logic din,
   output logic dout
);

   logic meta_q;

   // Two flops; the first is read only by the second.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ### sim/pm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Processor and bridge standing at the far side of the block
// ----------------------------------------------------------------
module pm_host_model (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Processor management handshake.
   input wire logic mgmtInterruptN,
   output logic mgmtModeActiveN,
   // Bridge request level, commanded by the bench.
   input wire logic bridgeReq,
   output logic pin2Level,
   // Clock-run open-drain line.
   input wire logic clkRunOut,
   input wire logic clkRunOe,
   input wire logic agentHold,
   output logic clkRunIn
);
   logic [1:0] delayQ;

   // The processor enters management mode three cycles after the request.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         delayQ <= 2'h0;
         mgmtModeActiveN <= 1'b1;
      end else begin
         delayQ <= {delayQ[0], ~mgmtInterruptN};
         mgmtModeActiveN <= ~delayQ[1];
      end
   end

   // The bridge holds the pin high while it wants the bus or wakes.
   assign pin2Level = bridgeReq;

   // The line has a pull-up; an agent answers by holding it low.
   assign clkRunIn = ((clkRunOe && !clkRunOut) || agentHold) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pm_pin_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] cpuAddr = 32'h0;
   logic externalActivityIn = 1'b0;
   logic [1:0] resumeRequest = 2'h0;
   logic powerSwitchInput = 1'b0;
   logic [3:0] gpioDrv = 4'h0;
   logic bridgeReq = 1'b0;
   logic agentHold = 1'b0;
   logic [31:0] prdata, r, g;
   logic pready, pslverr, e, mgmtInterruptN, mgmtModeActiveN;
   logic stopClockRequestN, mgmtMemorySelect, clkRunIn, clkRunOut;
   logic clkRunOe, primaryActivity, secondaryActivity, dmaReq, pin2Level;
   logic [3:0] gpioOut, gpioOe, gpioIn;
   logic [31:0] addrs [6];
   int regM [5];
   int errors = 0;
   int checks = 0;
   int i, j;

   // Pins driven by the block win over the bench's own level.
   assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & {gpioDrv[3], pin2Level,
      gpioDrv[1:0]});
   always #10 mclk = ~mclk;

   power_management_pin_control #(.PIN_FUNC_INIT(PIN_FUNC_RESET)) DUT (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mgmtInterruptN(mgmtInterruptN),
      .mgmtModeActiveN(mgmtModeActiveN),
      .stopClockRequestN(stopClockRequestN), .cpuAddr(cpuAddr),
      .mgmtMemorySelect(mgmtMemorySelect),
      .externalActivityIn(externalActivityIn),
      .resumeRequest(resumeRequest), .powerSwitchInput(powerSwitchInput),
      .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .clkRunIn(clkRunIn), .clkRunOut(clkRunOut), .clkRunOe(clkRunOe),
      .primaryActivity(primaryActivity),
      .secondaryActivity(secondaryActivity),
      .distributedDmaBusRequest(dmaReq));

   pm_host_model host (
      .mclk(mclk), .rst_n(rst_n), .mgmtInterruptN(mgmtInterruptN),
      .mgmtModeActiveN(mgmtModeActiveN), .bridgeReq(bridgeReq),
      .pin2Level(pin2Level), .clkRunOut(clkRunOut), .clkRunOe(clkRunOe),
      .agentHold(agentHold), .clkRunIn(clkRunIn));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Ends the run with the counts and the verdict.
   task print_verdict;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen high at an edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         print_verdict;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Writes a register and keeps the bench's copy of it.
   task wr(input logic [7:0] a, input int d);
      apb(1'b1, a, d);
      regM[a[4:2]] = d;
   endtask

   // Reads a register and compares it with the bench's copy.
   task rdreg(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      chk(r, regM[a[4:2]]);
   endtask

   // Lets synchronisers and registered outputs settle.
   task settle;
      repeat (6) @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(34900));
      regM = '{PIN_FUNC_RESET, MASK_RESET, CTRL_RESET, 0, 0};
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rdreg(PIN_FUNC_OFS);
      rdreg(MASK_OFS);
      rdreg(CTRL_OFS);
      apb(1'b0, 8'h40, 32'h0);
      chk({r[31:1], e}, 32'h1);
      // Window edges, one random inside and one random anywhere.
      addrs = '{32'h0009ffff, MGMT_MEM_LO, MGMT_MEM_HI, 32'h000c0000,
         MGMT_MEM_LO + ($urandom % 32'h20000), $urandom};
      for (j = 1; j >= 0; j--) begin
         wr(CTRL_OFS, j);
         settle;
         chk(mgmtInterruptN, !j);
         for (i = 0; i < 6; i++) begin
            cpuAddr <= addrs[i];
            settle;
            chk(mgmtMemorySelect, j && addrs[i] >= MGMT_MEM_LO &&
               addrs[i] <= MGMT_MEM_HI);
         end
      end
      wr(CTRL_OFS, 32'h2);
      settle;
      chk(stopClockRequestN, 1'b0);
      // Each setting of the two external-activity mask bits against both activity levels.
      for (i = 0; i < 8; i++) begin
         wr(MASK_OFS, 32'h10 | (i & 3));
         externalActivityIn <= i[2];
         settle;
         chk({primaryActivity, secondaryActivity},
            {i[2] & i[0], i[2] & i[1]});
      end
      externalActivityIn <= 1'b0;
      // All pins as general I/O with random enables, random drive on pins 0, 1 and 3.
      g = $urandom & 32'hff;
      gpioDrv <= $urandom;
      wr(PIN_FUNC_OFS, 32'h0);
      wr(GPIO_OFS, g);
      settle;
      chk({gpioOe, gpioOut}, g[7:0]);
      apb(1'b0, GPIO_OFS, 32'h0);
      chk(r[11:8], (g[7:4] & g[3:0]) | (~g[7:4] & {gpioDrv[3], bridgeReq,
         gpioDrv[1:0]}));
      // Indicator outputs on pins 0 and 1.
      wr(PIN_FUNC_OFS, 32'h05);
      for (i = 1; i < 3; i++) begin
         wr(CTRL_OFS, i << 4);
         settle;
         chk({gpioOe[1:0], gpioOut[1:0]}, {2'b11, i[1:0]});
      end
      // Bus request only when pin 2 carries that function.
      bridgeReq <= 1'b1;
      settle;
      chk(dmaReq, 1'b0);
      wr(PIN_FUNC_OFS, 32'h10);
      settle;
      chk(dmaReq, 1'b1);
      bridgeReq <= 1'b0;
      // Suspend: activity cannot wake, inhibit blocks, resume wakes.
      wr(PIN_FUNC_OFS, 32'h40);
      wr(MASK_OFS, 32'h1f);
      wr(CTRL_OFS, 32'h4);
      externalActivityIn <= 1'b1;
      settle;
      externalActivityIn <= 1'b0;
      gpioDrv <= 4'h8;
      settle;
      chk(stopClockRequestN, 1'b0);
      resumeRequest <= 2'b01;
      settle;
      chk(stopClockRequestN, 1'b0);
      resumeRequest <= 2'b00;
      gpioDrv <= 4'h0;
      settle;
      resumeRequest <= 2'b10;
      settle;
      chk(stopClockRequestN, 1'b1);
      resumeRequest <= 2'b00;
      regM[2] = 0;
      rdreg(CTRL_OFS);
      // Deep sleep woken by the bridge's IRQ activity on pin 2.
      wr(PIN_FUNC_OFS, 32'h20);
      wr(MASK_OFS, 32'h80);
      wr(CTRL_OFS, 32'hc);
      settle;
      chk(stopClockRequestN, 1'b0);
      bridgeReq <= 1'b1;
      settle;
      chk(stopClockRequestN, 1'b1);
      bridgeReq <= 1'b0;
      // Power switch wakes by default mask, then raises activity.
      wr(MASK_OFS, MASK_RESET);
      wr(CTRL_OFS, 32'h4);
      settle;
      powerSwitchInput <= 1'b1;
      settle;
      chk(stopClockRequestN, 1'b1);
      wr(MASK_OFS, 32'h20);
      settle;
      chk(primaryActivity, 1'b1);
      powerSwitchInput <= 1'b0;
      // Clock-run: release the line, then an agent holds it low.
      wr(CTRL_OFS, 32'h40);
      for (i = 0; i < 2; i++) begin
         agentHold <= i[0];
         settle;
         apb(1'b0, STATUS_OFS, 32'h0);
         chk({clkRunOe, r[ST_CLKOK_BIT]}, {1'b0, !i[0]});
      end
      print_verdict;
   end

   // Cuts a hung run short.
   initial begin
      #(20000 * 20);
      errors++;
      print_verdict;
   end
endmodule
`default_nettype wire
